// [cas_alert_status.sv]
// Comparator alert flags, balance switch faults and soft reset request
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module cas_alert_status (
   input  wire logic                            ref_clk,
   input  wire logic                            rst,
   input  wire logic [cas_pkg::CAS_ADDR_W-1:0]  reg_addr,
   input  wire logic [cas_pkg::CAS_DATA_W-1:0]  reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [cas_pkg::CAS_DATA_W-1:0]  reg_rdata,
   input  wire logic                            acq_done,
   input  wire logic [cas_pkg::CAS_CELLS-1:0]   cell_below_cmp,
   input  wire logic [cas_pkg::CAS_CELLS-1:0]   cell_under_alert_enable,
   input  wire logic [cas_pkg::CAS_AUX-1:0]     aux_above_cmp,
   input  wire logic [cas_pkg::CAS_AUX-1:0]     aux_over_alert_enable,
   input  wire logic [cas_pkg::CAS_AUX-1:0]     aux_below_cmp,
   input  wire logic [cas_pkg::CAS_AUX-1:0]     aux_under_alert_enable,
   input  wire logic [cas_pkg::CAS_CELLS-1:0]   bal_diag_fail,
   input  wire logic [cas_pkg::CAS_SCAN_W-1:0]  scan_select,
   input  wire logic [cas_pkg::CAS_TOP_W-1:0]   top_position_one,
   output logic                                 soft_reset_request,
   output logic      [cas_pkg::CAS_UART_W-1:0]  serial_port_layout,
   output logic                                 irq
);
   import cas_pkg::*;

   typedef struct packed {
      logic [CAS_CELLS-1:0]  cell_under;
      logic [CAS_AUX-1:0]    aux_over;
      logic [CAS_AUX-1:0]    aux_under;
      logic [CAS_CELLS-1:0]  bal_sw;
      logic [CAS_UART_W-1:0] uart;
      logic [CAS_EVENTS-1:0] int_status;
      logic [CAS_EVENTS-1:0] int_mask;
      cas_rst_state_t        rst_state;
      logic [CAS_DATA_W-1:0] rdata;
      logic                  irq;
   } cas_state_t;

   cas_state_t state_reg;
   cas_state_t state_next;
   logic [CAS_CELLS-1:0] top_mask;
   logic [CAS_CELLS-1:0] bal_eval;
   logic                 bal_scan;
   logic [CAS_EVENTS-1:0] ev;

   // Balance switch positions above the top cell are never tested
   genvar gi;
   generate
      for (gi = 0; gi < CAS_CELLS; gi++) begin : g_top
         assign top_mask[gi] = (gi <= int'(top_position_one));
      end
   endgenerate

   assign bal_scan = (scan_select >= CAS_SCAN_BAL_MIN);
   assign bal_eval = bal_diag_fail & top_mask;

   always_comb begin
      state_next = state_reg;
      ev = '0;
      state_next.rdata = '0;
      // Each acquisition re-evaluates the comparator flags (balance flags only on a diagnostic scan), so a resolved one clears
      if (acq_done) begin
         state_next.cell_under = cell_below_cmp
                               & cell_under_alert_enable;
         state_next.aux_over = aux_above_cmp
                             & aux_over_alert_enable;
         state_next.aux_under = aux_below_cmp
                              & aux_under_alert_enable;
         if (bal_scan) begin
            state_next.bal_sw = bal_eval;
         end
         ev[CAS_EV_CELL] = |state_next.cell_under;
         ev[CAS_EV_AUXO] = |state_next.aux_over;
         ev[CAS_EV_AUXU] = |state_next.aux_under;
         ev[CAS_EV_BAL]  = |state_next.bal_sw;
      end
      // Masking again guards against a lowered top cell between scans
      state_next.bal_sw = state_next.bal_sw & top_mask;
      state_next.rst_state = CAS_IDLE;
      if (reg_wr) begin
         case (reg_addr)
            CAS_OFF_SW_ACTION: begin
               if (reg_wdata[CAS_SOFT_RESET_BIT]) begin
                  state_next.rst_state = CAS_PULSE;
               end
            end
            CAS_OFF_SERIAL_CFG: begin
               state_next.uart = reg_wdata[CAS_UART_LSB +: CAS_UART_W];
            end
            CAS_OFF_INT_STATUS: begin
               state_next.int_status = state_reg.int_status
                                     & ~reg_wdata[CAS_EVENTS-1:0];
            end
            CAS_OFF_INT_MASK: begin
               state_next.int_mask = reg_wdata[CAS_EVENTS-1:0];
            end
            default: begin
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      state_next.int_status = state_next.int_status | ev;
      if (reg_rd) begin
         case (reg_addr)
            CAS_OFF_CELL_UNDER:
               state_next.rdata = CAS_DATA_W'(state_reg.cell_under);
            CAS_OFF_AUX_OVER:
               state_next.rdata = CAS_DATA_W'(state_reg.aux_over);
            CAS_OFF_AUX_UNDER:
               state_next.rdata = CAS_DATA_W'(state_reg.aux_under);
            CAS_OFF_BAL_SW:
               state_next.rdata = CAS_DATA_W'(state_reg.bal_sw);
            CAS_OFF_SW_ACTION:
               state_next.rdata = '0;
            CAS_OFF_SERIAL_CFG:
               state_next.rdata = {state_reg.uart,
                                   {(CAS_DATA_W-CAS_UART_W){1'b0}}};
            CAS_OFF_INT_STATUS:
               state_next.rdata = CAS_DATA_W'(state_reg.int_status);
            CAS_OFF_INT_MASK:
               state_next.rdata = CAS_DATA_W'(state_reg.int_mask);
            default:
               state_next.rdata = '0;
         endcase
      end
      state_next.irq = |(state_next.int_status & state_next.int_mask);
   end

   // Soft reset is only reported out; the layout field is kept deliberately
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg.cell_under <= '0;
         state_reg.aux_over   <= '0;
         state_reg.aux_under  <= '0;
         state_reg.bal_sw     <= '0;
         state_reg.uart       <= CAS_UART_RST;
         state_reg.int_status <= CAS_EV_RST;
         state_reg.int_mask   <= CAS_EV_RST;
         state_reg.rst_state  <= CAS_IDLE;
         state_reg.rdata      <= '0;
         state_reg.irq        <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata          = state_reg.rdata;
   assign soft_reset_request = (state_reg.rst_state == CAS_PULSE);
   assign serial_port_layout = state_reg.uart;
   assign irq                = state_reg.irq;

   cell_flag_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done |=> state_reg.cell_under
         == $past(cell_below_cmp & cell_under_alert_enable))
      else $error("cell flag wrong after acquisition");
   cell_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !acq_done |=> $stable(state_reg.cell_under))
      else $error("cell flag changed without acquisition");
   cell_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && cell_below_cmp == '0
         |=> state_reg.cell_under == '0)
      else $error("cell flag not cleared when resolved");
   aux_over_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done |=> state_reg.aux_over
         == $past(aux_above_cmp & aux_over_alert_enable))
      else $error("aux over flag wrong");
   aux_over_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !acq_done |=> $stable(state_reg.aux_over))
      else $error("aux over flag changed between acquisitions");
   aux_over_clr_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && aux_above_cmp == '0 |=> state_reg.aux_over == '0)
      else $error("aux over flag not cleared when resolved");
   aux_under_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done |=> state_reg.aux_under
         == $past(aux_below_cmp & aux_under_alert_enable))
      else $error("aux under flag wrong");
   aux_under_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && !acq_done |=> $stable(state_reg.aux_under))
      else $error("aux under flag changed on read");
   aux_under_clr_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && aux_below_cmp == '0 |=> state_reg.aux_under == '0)
      else $error("aux under flag not cleared when resolved");
   bal_scan_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && bal_scan && $stable(top_position_one)
         |=> state_reg.bal_sw == $past(bal_eval))
      else $error("balance flag wrong after scan");
   bal_top_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (state_reg.bal_sw & ~$past(top_mask)) == '0)
      else $error("balance flag above top cell");
   bal_keep_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && !bal_scan && $stable(top_mask)
         |=> state_reg.bal_sw == $past(state_reg.bal_sw))
      else $error("balance flag cleared without scan");
   bal_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !acq_done && $stable(top_mask) |=> $stable(state_reg.bal_sw))
      else $error("balance flag changed without acquisition");
   soft_pulse_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_SW_ACTION
         && reg_wdata[CAS_SOFT_RESET_BIT] |=> soft_reset_request)
      else $error("soft reset pulse missing");
   soft_only_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      soft_reset_request |-> $past(reg_wr && reg_addr == CAS_OFF_SW_ACTION
         && reg_wdata[CAS_SOFT_RESET_BIT]))
      else $error("soft reset pulse without request");
   soft_zero_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_SW_ACTION
         && !reg_wdata[CAS_SOFT_RESET_BIT] |=> !soft_reset_request)
      else $error("soft reset pulse on zero write");
   soft_read_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_SW_ACTION |=> reg_rdata == '0)
      else $error("action register read not zero");
   layout_keep_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      soft_reset_request |=> $stable(serial_port_layout)
         || $past(reg_wr))
      else $error("layout changed by soft reset");
   layout_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_SERIAL_CFG |=> serial_port_layout
         == $past(reg_wdata[CAS_UART_LSB +: CAS_UART_W]))
      else $error("layout write not taken");
   layout_other_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !(reg_wr && reg_addr == CAS_OFF_SERIAL_CFG)
         |=> $stable(serial_port_layout))
      else $error("layout changed without its write");
   read_keep_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_CELL_UNDER && !acq_done
         |=> $stable(state_reg.cell_under))
      else $error("read altered flags");
   rd_cell_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_CELL_UNDER
         |=> reg_rdata == CAS_DATA_W'($past(state_reg.cell_under)))
      else $error("cell flag read data wrong");
   rd_bal_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_BAL_SW
         |=> reg_rdata == CAS_DATA_W'($past(state_reg.bal_sw)))
      else $error("balance flag read data wrong");
   rd_auxo_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_AUX_OVER
         |=> reg_rdata == CAS_DATA_W'($past(state_reg.aux_over)))
      else $error("aux over read data wrong");
   rd_auxu_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == CAS_OFF_AUX_UNDER
         |=> reg_rdata == CAS_DATA_W'($past(state_reg.aux_under)))
      else $error("aux under read data wrong");
   rdata_idle_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside read");
   irq_level_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      irq == |(state_reg.int_status & state_reg.int_mask))
      else $error("interrupt level wrong");
   stat_cell_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && |(cell_below_cmp & cell_under_alert_enable)
         |=> state_reg.int_status[CAS_EV_CELL])
      else $error("cell event not recorded");
   stat_bal_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      acq_done && bal_scan && |bal_eval
         |=> state_reg.int_status[CAS_EV_BAL])
      else $error("balance event not recorded");
   stat_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_INT_STATUS && !acq_done
         |=> (state_reg.int_status & $past(reg_wdata[CAS_EVENTS-1:0])) == '0)
      else $error("status bits not cleared by write");
   mask_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_INT_MASK
         |=> state_reg.int_mask == $past(reg_wdata[CAS_EVENTS-1:0]))
      else $error("mask write not taken");

   cov_cell_c: cover property (@(posedge ref_clk) disable iff (rst)
      acq_done ##1 state_reg.cell_under != '0);
   cov_bal_c: cover property (@(posedge ref_clk) disable iff (rst)
      acq_done && bal_scan ##1 state_reg.bal_sw != '0);
   cov_soft_c: cover property (@(posedge ref_clk) disable iff (rst)
      soft_reset_request);
   cov_irq_c: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(irq));
   cov_clear_c: cover property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == CAS_OFF_INT_STATUS && acq_done);
endmodule

// [cas_pkg.sv]
// Package for the comparator alert status and soft reset block
package cas_pkg;
   localparam int CAS_ADDR_W = 8;
   localparam int CAS_DATA_W = 16;
   localparam int CAS_CELLS = 14;
   localparam int CAS_AUX = 4;
   localparam int CAS_SCAN_W = 3;
   localparam int CAS_TOP_W = 4;
   localparam int CAS_UART_W = 2;
   // Register offsets
   localparam logic [7:0] CAS_OFF_CELL_UNDER = 8'h0F;
   localparam logic [7:0] CAS_OFF_AUX_OVER   = 8'h10;
   localparam logic [7:0] CAS_OFF_AUX_UNDER  = 8'h11;
   localparam logic [7:0] CAS_OFF_BAL_SW     = 8'h12;
   localparam logic [7:0] CAS_OFF_SW_ACTION  = 8'h13;
   localparam logic [7:0] CAS_OFF_SERIAL_CFG = 8'h14;
   localparam logic [7:0] CAS_OFF_INT_STATUS = 8'h20;
   localparam logic [7:0] CAS_OFF_INT_MASK   = 8'h21;
   // Field positions and reset values
   localparam int CAS_SOFT_RESET_BIT = 0;
   localparam int CAS_UART_LSB = 14;
   localparam logic [1:0] CAS_UART_RST = 2'h3;
   localparam logic [2:0] CAS_SCAN_BAL_MIN = 3'h4;
   localparam int CAS_EVENTS = 4;
   localparam int CAS_EV_CELL = 0;
   localparam int CAS_EV_AUXO = 1;
   localparam int CAS_EV_AUXU = 2;
   localparam int CAS_EV_BAL  = 3;
   localparam logic [3:0] CAS_EV_RST = 4'h0;
   typedef enum logic [0:0] {
      CAS_IDLE  = 1'b0,
      CAS_PULSE = 1'b1
   } cas_rst_state_t;
endpackage

// [tb_cas_alert_status.sv]
// Self-checking testbench for the comparator alert status block
`timescale 1ns/1ps
module tb_cas_alert_status;
   import cas_pkg::*;
   logic                  ref_clk;
   logic                  rst;
   logic [CAS_ADDR_W-1:0] reg_addr;
   logic [CAS_DATA_W-1:0] reg_wdata;
   logic [CAS_DATA_W-1:0] reg_rdata;
   logic                  reg_wr, reg_rd, acq_done, soft_reset_request, irq;
   logic [CAS_CELLS-1:0]  cell_below_cmp, cell_under_alert_enable;
   logic [CAS_CELLS-1:0]  bal_diag_fail;
   logic [CAS_AUX-1:0]    aux_above_cmp, aux_over_alert_enable;
   logic [CAS_AUX-1:0]    aux_below_cmp, aux_under_alert_enable;
   logic [CAS_SCAN_W-1:0] scan_select;
   logic [CAS_TOP_W-1:0]  top_position_one;
   logic [CAS_UART_W-1:0] serial_port_layout;
   int                    n_errors, tests_run;

   cas_alert_status u_dut (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_done(acq_done),
      .cell_below_cmp(cell_below_cmp),
      .cell_under_alert_enable(cell_under_alert_enable),
      .aux_above_cmp(aux_above_cmp),
      .aux_over_alert_enable(aux_over_alert_enable),
      .aux_below_cmp(aux_below_cmp),
      .aux_under_alert_enable(aux_under_alert_enable),
      .bal_diag_fail(bal_diag_fail), .scan_select(scan_select),
      .top_position_one(top_position_one),
      .soft_reset_request(soft_reset_request),
      .serial_port_layout(serial_port_layout), .irq(irq));

   always #20 ref_clk = ~ref_clk;

   task automatic tally_and_finish;
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Returns just after the edge that takes the write
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk_word(reg_rdata, exp);
   endtask

   task automatic acq;
      @(posedge ref_clk);
      acq_done <= 1'b1;
      @(posedge ref_clk);
      acq_done <= 1'b0;
      #1;
   endtask

   initial begin
      #200000;
      n_errors++;
      tally_and_finish;
   end

   initial begin
      ref_clk = 1'b0; rst = 1'b1; reg_addr = '0; reg_wdata = '0;
      reg_wr = 1'b0; reg_rd = 1'b0; acq_done = 1'b0; scan_select = '0;
      cell_below_cmp = '0; cell_under_alert_enable = '0; bal_diag_fail = '0;
      aux_above_cmp = '0; aux_over_alert_enable = '0; aux_below_cmp = '0;
      aux_under_alert_enable = '0; top_position_one = '0;
      n_errors = 0; tests_run = 0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 8'h0F; a <= 8'h13; a++) rd_chk(8'(a), 16'h0000);
      rd_chk(8'h21, 16'h0000);
      rd_chk(8'h30, 16'h0000);
      chk_word(16'(serial_port_layout), 16'h0003);
      @(posedge ref_clk);
      cell_below_cmp <= 14'h3FFF;
      cell_under_alert_enable <= 14'h2AAA;
      aux_above_cmp <= 4'hF; aux_over_alert_enable <= 4'h5;
      aux_below_cmp <= 4'hF; aux_under_alert_enable <= 4'hA;
      bal_diag_fail <= 14'h3FFF; scan_select <= 3'h3;
      top_position_one <= 4'h9;
      acq;
      rd_chk(8'h0F, 16'h2AAA);
      rd_chk(8'h0F, 16'h2AAA);
      rd_chk(8'h10, 16'h0005);
      rd_chk(8'h11, 16'h000A);
      rd_chk(8'h12, 16'h0000);
      @(posedge ref_clk);
      scan_select <= 3'h4;
      cell_below_cmp <= 14'h0002;
      acq;
      rd_chk(8'h0F, 16'h0002);
      rd_chk(8'h12, 16'h03FF);
      // Every balance diagnostic code, one failing cell each
      for (int s = 4; s <= 7; s++) begin
         @(posedge ref_clk);
         scan_select <= 3'(s);
         bal_diag_fail <= 14'h0001 << s;
         acq;
         rd_chk(8'h12, 16'h0001 << s);
      end
      rd_chk(8'h20, 16'h000F);
      chk_word(16'(irq), 16'h0000);
      wr(8'h21, 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_word(16'(irq), 16'h0001);
      wr(8'h20, 16'h000F);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_word(16'(irq), 16'h0000);
      rd_chk(8'h20, 16'h0000);
      // Event and clear in one cycle: the event must win
      @(posedge ref_clk);
      reg_addr <= 8'h20;
      reg_wdata <= 16'h000F;
      reg_wr <= 1'b1;
      acq_done <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      acq_done <= 1'b0;
      rd_chk(8'h20, 16'h000F);
      // Writes to read-only flags are ignored
      wr(8'h0F, 16'hFFFF);
      rd_chk(8'h0F, 16'h0002);
      // Non-diagnostic scan code must hold the switch flags
      @(posedge ref_clk);
      cell_below_cmp <= '0; aux_above_cmp <= '0; aux_below_cmp <= '0;
      bal_diag_fail <= '0; scan_select <= 3'h0;
      acq;
      rd_chk(8'h0F, 16'h0000);
      rd_chk(8'h10, 16'h0000);
      rd_chk(8'h11, 16'h0000);
      rd_chk(8'h12, 16'h0080);
      @(posedge ref_clk);
      top_position_one <= 4'h6;
      rd_chk(8'h12, 16'h0000);
      @(posedge ref_clk);
      scan_select <= 3'h7;
      acq;
      rd_chk(8'h12, 16'h0000);
      // Recovery-style soft reset after a layout change
      wr(8'h14, 16'h4000);
      wr(8'h13, 16'h0001);
      chk_word(16'(soft_reset_request), 16'h0001);
      @(posedge ref_clk);
      #1;
      chk_word(16'(soft_reset_request), 16'h0000);
      rd_chk(8'h13, 16'h0000);
      chk_word(16'(serial_port_layout), 16'h0001);
      wr(8'h13, 16'h0000);
      chk_word(16'(soft_reset_request), 16'h0000);
      tally_and_finish;
   end
endmodule
